// ---- srh_pkg.sv ----
// Package for the host-side controller of a 16384 x 1 asynchronous static memory
// Notes on behaviour
// - Host keeps select low at least 55 ns before write end.
// - Host holds address at least 55 ns before write end; setup may be zero.
// - Host presents data at least 30 ns before write end; hold is zero.
// - Write cycle of at least 70 ns, last valid address to next change.
package srh_pkg;
    localparam int SRH_ADDR_W = 14;
    localparam int SRH_DEPTH = 16384;
    localparam int SRH_CLK_NS = 20;
    // Timing figures in ns
    localparam int SRH_ADDRESS_TO_DATA_DELAY_NS = 70;
    localparam int SRH_SELECT_TO_DATA_DELAY_NS = 70;
    localparam int SRH_ADDRESS_BEFORE_WRITE_END_NS = 55;
    localparam int SRH_SELECT_BEFORE_WRITE_END_NS = 55;
    localparam int SRH_DATA_BEFORE_WRITE_END_NS = 30;
    localparam int SRH_READ_PERIOD_MINIMUM_NS = 70;
    localparam int SRH_WRITE_PERIOD_MINIMUM_NS = 70;
    // Least times round up to whole cycles
    localparam int SRH_RD_CYC_I = (SRH_ADDRESS_TO_DATA_DELAY_NS + SRH_CLK_NS - 1) / SRH_CLK_NS;
    localparam int SRH_RP_CYC_I = (SRH_READ_PERIOD_MINIMUM_NS + SRH_CLK_NS - 1) / SRH_CLK_NS;
    localparam int SRH_WE_CYC_I =
        (SRH_SELECT_BEFORE_WRITE_END_NS + SRH_CLK_NS - 1) / SRH_CLK_NS;
    localparam int SRH_WP_CYC_I = (SRH_WRITE_PERIOD_MINIMUM_NS + SRH_CLK_NS - 1) / SRH_CLK_NS;
    localparam int SRH_CNT_W = 3;
    // Cycles strobes stay low before sampling read data / ending a write
    localparam logic [SRH_CNT_W-1:0] SRH_RD_CYC = SRH_CNT_W'(
        (SRH_RD_CYC_I > SRH_RP_CYC_I) ? SRH_RD_CYC_I : SRH_RP_CYC_I);
    localparam logic [SRH_CNT_W-1:0] SRH_WR_CYC = SRH_CNT_W'(
        (SRH_WE_CYC_I > SRH_WP_CYC_I - 1) ? SRH_WE_CYC_I : SRH_WP_CYC_I - 1);
    localparam logic [SRH_CNT_W-1:0] SRH_CNT_ONE = 3'h1;
    localparam logic [SRH_CNT_W-1:0] SRH_CNT_ZERO = 3'h0;

    typedef struct packed {
        logic write;
        logic [SRH_ADDR_W-1:0] addr;
        logic wdata;
    } srh_req_t;

    typedef struct packed {
        logic select_n;
        logic write_n;
        logic [SRH_ADDR_W-1:0] addr;
        logic din;
    } srh_pins_t;

    typedef enum logic [1:0] {
        SRH_IDLE = 2'b00,
        SRH_READ = 2'b01,
        SRH_WRITE = 2'b10,
        SRH_RECOVER = 2'b11
    } srh_state_t;
endpackage

// ---- srh_timer.sv ----
// Down counter that times the strobe phases of one memory cycle
`timescale 1ns/10ps
module srh_timer (
    // Clock and control
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Load and status
    input wire logic load,
    input wire logic [srh_pkg::SRH_CNT_W-1:0] load_val,
    output logic done
);
    import srh_pkg::*;
    logic [SRH_CNT_W-1:0] cnt_reg;
    logic [SRH_CNT_W-1:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = load_val;
        end else if (cnt_reg != SRH_CNT_ZERO) begin
            cnt_next = cnt_reg - SRH_CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt_reg <= SRH_CNT_ZERO;
        end else if (ce) begin
            cnt_reg <= cnt_next;
        end
    end

    assign done = (cnt_reg == SRH_CNT_ONE);
endmodule

// ---- srh_host.sv ----
// Host controller driving a 16384 x 1 asynchronous static memory through its pins
`timescale 1ns/10ps
module srh_host (
    // Clock and control
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // User request
    input wire logic req_valid,
    input wire srh_pkg::srh_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_rdata,
    // Memory pins
    output srh_pkg::srh_pins_t mem_pins,
    input wire logic mem_dout
);
    import srh_pkg::*;

    srh_state_t state_reg;
    srh_state_t state_next;
    srh_pins_t pins_reg;
    srh_pins_t pins_next;
    logic ready_reg;
    logic ready_next;
    logic rsp_valid_reg;
    logic rsp_valid_next;
    logic rdata_reg;
    logic rdata_next;
    logic tmr_load;
    logic [SRH_CNT_W-1:0] tmr_val;
    logic tmr_done;

    srh_timer u_timer (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    always_comb begin
        state_next = state_reg;
        pins_next = pins_reg;
        ready_next = ready_reg;
        rsp_valid_next = 1'b0;
        rdata_next = rdata_reg;
        tmr_load = 1'b0;
        tmr_val = SRH_RD_CYC;
        case (state_reg)
            SRH_IDLE: begin
                // Ready rises one cycle after reset so the first take sees settled pins
                ready_next = 1'b1;
                if (req_valid && ready_reg) begin
                    // Address, data and select change together: zero setup is allowed
                    pins_next.addr = req.addr;
                    pins_next.din = req.wdata;
                    pins_next.select_n = 1'b0;
                    pins_next.write_n = !req.write;
                    ready_next = 1'b0;
                    tmr_load = 1'b1;
                    if (req.write) begin
                        tmr_val = SRH_WR_CYC;
                        state_next = SRH_WRITE;
                    end else begin
                        tmr_val = SRH_RD_CYC;
                        state_next = SRH_READ;
                    end
                end
            end
            SRH_READ: begin
                if (tmr_done) begin
                    // Sampled after the access time, before any address change
                    rdata_next = mem_dout;
                    rsp_valid_next = 1'b1;
                    pins_next.select_n = 1'b1;
                    state_next = SRH_RECOVER;
                end
            end
            SRH_WRITE: begin
                if (tmr_done) begin
                    // Both strobes rise together so the output never glitches on
                    pins_next.select_n = 1'b1;
                    pins_next.write_n = 1'b1;
                    rsp_valid_next = 1'b1;
                    state_next = SRH_RECOVER;
                end
            end
            default: begin
                // Address held one more cycle: zero hold met, cycle length kept
                ready_next = 1'b1;
                state_next = SRH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_reg <= SRH_IDLE;
            pins_reg <= '{select_n: 1'b1, write_n: 1'b1, addr: '0, din: 1'b0};
            ready_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rdata_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            pins_reg <= pins_next;
            ready_reg <= ready_next;
            rsp_valid_reg <= rsp_valid_next;
            rdata_reg <= rdata_next;
        end
    end

    // Age of the current address in enabled cycles; saturates so long idles never wrap
    localparam logic [SRH_CNT_W-1:0] AGE_SAT = {SRH_CNT_W{1'b1}};
    localparam logic [SRH_CNT_W-1:0] ADDR_HOLD_MIN = SRH_CNT_W'(SRH_WP_CYC_I - 1);
    logic [SRH_CNT_W-1:0] age_reg;
    logic [SRH_CNT_W-1:0] age_next;

    always_comb begin
        age_next = age_reg;
        if (pins_next.addr != pins_reg.addr) begin
            age_next = SRH_CNT_ZERO;
        end else if (age_reg != AGE_SAT) begin
            age_next = age_reg + SRH_CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            // Reset counts as an old address so the first take is not flagged
            age_reg <= AGE_SAT;
        end else if (ce) begin
            age_reg <= age_next;
        end
    end

    assign mem_pins = pins_reg;
    assign req_ready = ready_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rdata_reg;

    // A write opens when the strobe falls on an enabled cycle
    sequence s_write_open;
        $fell(mem_pins.write_n) && ce;
    endsequence

    // A read opens when select falls with the strobe high
    sequence s_read_open;
        $fell(mem_pins.select_n) && mem_pins.write_n && ce;
    endsequence

    // Enabled cycles in which the strobe timer keeps counting
    sequence s_enabled_run;
        ce [*3];
    endsequence

    a_write_sel_width: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_write_open |-> !mem_pins.select_n [*3]
    ) else $error("select released too early in write");

    a_write_end: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_write_open ##1 ce [*2] |=> $rose(mem_pins.write_n)
    ) else $error("write strobe not ended on time");

    a_strobes_rise: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(mem_pins.write_n) |-> $rose(mem_pins.select_n)
    ) else $error("write strobe rose without select");

    a_addr_stable: assert property (@(posedge clk_sys) disable iff (!rstn)
        !mem_pins.select_n |-> $stable(mem_pins.addr) || $fell(mem_pins.select_n)
    ) else $error("address moved while selected");

    a_data_stable: assert property (@(posedge clk_sys) disable iff (!rstn)
        !mem_pins.write_n && !$fell(mem_pins.write_n) |-> $stable(mem_pins.din)
    ) else $error("write data moved during write");

    a_no_write_deselected: assert property (@(posedge clk_sys) disable iff (!rstn)
        !mem_pins.write_n |-> !mem_pins.select_n
    ) else $error("write strobe low while deselected");

    a_cycle_spacing: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(mem_pins.select_n) |=> mem_pins.select_n
    ) else $error("cycles spaced too closely");

    a_read_resp: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_read_open ##1 s_enabled_run |=> ##[0:1] rsp_valid
    ) else $error("read answer late");

    a_read_width: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(mem_pins.select_n) && mem_pins.write_n |-> !mem_pins.select_n [*4]
    ) else $error("read select too short");

    a_take_pins: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && req_valid && req_ready |=> !mem_pins.select_n
            && mem_pins.addr == $past(req.addr) && mem_pins.din == $past(req.wdata)
            && mem_pins.write_n == !$past(req.write)
    ) else $error("pins do not carry the request taken");

    a_idle_deselect: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_reg == SRH_IDLE |-> mem_pins.select_n && mem_pins.write_n
    ) else $error("memory selected while idle");

    a_ready_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_reg != SRH_IDLE |-> !req_ready
    ) else $error("ready raised during a cycle");

    a_rsp_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
        rsp_valid && ce |=> !rsp_valid
    ) else $error("answer pulse longer than one cycle");

    a_read_sample: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && state_reg == SRH_READ && tmr_done |=> rsp_rdata == $past(mem_dout)
    ) else $error("read data not taken from the memory");

    a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && !(state_reg == SRH_READ && tmr_done) |=> $stable(rsp_rdata)
    ) else $error("read data changed outside a read");

    a_addr_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && (pins_next.addr != pins_reg.addr) |-> age_reg >= ADDR_HOLD_MIN
    ) else $error("address changed before the cycle time");

    a_ce_freeze: assert property (@(posedge clk_sys) disable iff (!rstn)
        !ce |=> $stable(mem_pins) && $stable(req_ready) && $stable(rsp_valid)
            && $stable(rsp_rdata)
    ) else $error("state moved while clock enable low");
endmodule

// ---- srh_mem_model.sv ----
// Behavioural 16384 x 1 static memory on the far side of the host
`timescale 1ns/10ps
module srh_mem_model #(parameter int ACC_NS = 70) (
    // Memory pins
    input wire srh_pkg::srh_pins_t pins,
    output logic dout
);
    import srh_pkg::*;
    logic mem [SRH_DEPTH];
    logic [1:0] sw_prev = 2'h3;
    realtime t_sel, t_adr, t_din;
    int viol = 0;
    initial dout = 1'h0;
    // Output is left alone on an address change, so old data always outlasts it
    always @(pins.addr) t_adr = $realtime;
    always @(pins.din) t_din = $realtime;
    always @(pins.select_n or pins.write_n) begin
        if (sw_prev[1] && !pins.select_n) t_sel = $realtime;
        // A write lands when the first strobe rises; zero hold is allowed
        if (sw_prev == 2'h0 && {pins.select_n, pins.write_n} != 2'h0) begin
            if ($realtime - t_sel < SRH_SELECT_BEFORE_WRITE_END_NS) viol++;
            if ($realtime - t_adr < SRH_ADDRESS_BEFORE_WRITE_END_NS) viol++;
            if ($realtime - t_din < SRH_DATA_BEFORE_WRITE_END_NS) viol++;
            mem[pins.addr] = pins.din;
        end
        sw_prev = {pins.select_n, pins.write_n};
        // No pull on the line: while not driven it shows the inverse level
        // Supply current is not modelled; deselect only floats the output
        dout = ~dout;
        if (sw_prev == 2'h1) dout <= #(ACC_NS) mem[pins.addr];
    end
endmodule

// ---- srh_host_tb.sv ----
// Self-checking bench for the static memory host controller
`timescale 1ns/10ps
module srh_host_tb;
    import srh_pkg::*;
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    logic ce = 1'h1;
    logic req_valid = 1'h0;
    srh_req_t req = '0;
    logic req_ready, rsp_valid, rsp_rdata, mem_dout;
    srh_pins_t mem_pins;
    int n_errors = 0;
    int check_count = 0;
    always #10 clk_sys = ~clk_sys;
    srh_host DUT (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .mem_pins(mem_pins), .mem_dout(mem_dout));
    srh_mem_model mem (.pins(mem_pins), .dout(mem_dout));
    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic check_num(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            n_errors++;
            $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One transfer; counts cycles to the answer and how long each strobe is low
    task automatic xfer(input logic wr, input logic [SRH_ADDR_W-1:0] a, input logic d);
        int n;
        int ls;
        int lw;
        n = 0;
        ls = 0;
        lw = 0;
        req_valid = 1'h1;
        req = '{write: wr, addr: a, wdata: d};
        while (req_ready !== 1'h1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        @(posedge clk_sys);
        #1;
        req_valid = 1'h0;
        n = 0;
        while (rsp_valid !== 1'h1 && n < 20) begin
            ls += int'(mem_pins.select_n === 1'h0);
            lw += int'(mem_pins.write_n === 1'h0);
            @(posedge clk_sys);
            #1;
            n++;
        end
        check_num(n, wr ? 3 : 4);
        check_num(ls, wr ? 3 : 4);
        check_num(lw, wr ? 3 : 0);
        if (!wr) check_bit(rsp_rdata, d);
        @(posedge clk_sys);
        #1;
        check_bit(rsp_valid, 1'h0);
        check_bit(mem_pins.select_n, 1'h1);
    endtask
    // Clock enable held low in mid-read stretches the strobe but keeps the data
    task automatic scen_ce_stall;
        int n;
        n = 0;
        check_bit(req_ready, 1'h1);
        req_valid = 1'h1;
        req = '{write: 1'h0, addr: 14'h1555, wdata: 1'h0};
        @(posedge clk_sys);
        #1;
        req_valid = 1'h0;
        ce = 1'h0;
        repeat (3) @(posedge clk_sys);
        #1;
        check_bit(mem_pins.select_n, 1'h0);
        check_bit(rsp_valid, 1'h0);
        ce = 1'h1;
        while (rsp_valid !== 1'h1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check_num(n, 4);
        check_bit(rsp_rdata, 1'h1);
    endtask
    task automatic scen_reset;
        check_bit(mem_pins.select_n, 1'h1);
        check_bit(mem_pins.write_n, 1'h1);
        check_bit(req_ready, 1'h0);
        rstn = 1'h1;
    endtask
    // Back-to-back writes at both ends of the array, read back in reverse
    task automatic scen_walk;
        logic [SRH_ADDR_W-1:0] adr [4] = '{14'h0, 14'h3fff, 14'h1555, 14'h2aaa};
        for (int i = 0; i < 4; i++) xfer(1'h1, adr[i], i[0] ^ 1'h1);
        for (int i = 3; i >= 0; i--) xfer(1'h0, adr[i], i[0] ^ 1'h1);
    endtask
    task automatic scen_overwrite;
        xfer(1'h1, 14'h0, 1'h0);
        xfer(1'h0, 14'h0, 1'h0);
        xfer(1'h0, 14'h3fff, 1'h0);
        check_num(mem.viol, 0);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        scen_reset;
        scen_walk;
        scen_overwrite;
        scen_ce_stall;
        final_report;
    end
    initial begin
        #20000;
        n_errors++;
        final_report;
    end
endmodule
